// file: hdl/byte_fifo.sv
// Receive buffer with registered read data
`default_nettype none

module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  stream_if.snk wr,
  stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic out_valid;
    logic [W-1:0] out_data;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic push;
  logic pop;

  assign wr.ready = (s.count != (AW + 1)'(DEPTH));
  assign rd.valid = s.out_valid;
  assign rd.data = s.out_data;
  assign push = wr.valid && wr.ready;
  assign pop = (s.count != '0) && (!s.out_valid || rd.ready);

  always_comb
  begin
    next_s = s;
    if (rd.ready)
    begin
      next_s.out_valid = 1'b0;
    end
    if (push)
    begin
      next_s.mem[s.wr_ptr] = wr.data;
      next_s.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + AW'(1);
    end
    if (pop)
    begin
      next_s.out_valid = 1'b1;
      next_s.out_data = s.mem[s.rd_ptr];
      next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + AW'(1);
    end
    if (push && !pop)
    begin
      next_s.count = s.count + (AW + 1)'(1);
    end
    else if (pop && !push)
    begin
      next_s.count = s.count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
    s.count <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");

endmodule // byte_fifo

`default_nettype wire

// file: hdl/stream_if.sv
// Valid/ready byte stream between the port logic and its buffer
`default_nettype none

interface stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: hdl/uart_dce_defines.svh
// Constants for the power-saving serial port: timing, widths and reset values
`ifndef UART_DCE_DEFINES_SVH
`define UART_DCE_DEFINES_SVH

`define CLK_FREQ_HZ 100000000
`define WAKE_TIME_MS 20
`define WAKE_CYCLES (`WAKE_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define IDLE_TIME_US 2000
`define IDLE_CYCLES (`IDLE_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define POLL_TIME_US 1000
`define POLL_CYCLES (`POLL_TIME_US * (`CLK_FREQ_HZ / 1000000))
`define BAUD_DIVISOR 868
`define UART_DATA_BITS 8
`define UART_STOP_INDEX 9
`define FIFO_DEPTH 16
`define FLOW_ON_RESET 1'h1
`define PSV_RESET 2'h0
`define PIN_IDLE_LEVELS 3'h7

`endif

// file: hdl/uart_dce_pkg.sv
// Types shared by the power-saving serial port
`default_nettype none

package uart_dce_pkg;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h1,
    ST_IDLE = 3'h2,
    ST_WAKING = 3'h4
  } port_state_t;

  typedef enum logic [1:0] {
    PSV_OFF = 2'h0,
    PSV_PERIODIC = 2'h1,
    PSV_RTS = 2'h2,
    PSV_DTR = 2'h3
  } psv_mode_t;

endpackage

`default_nettype wire

// file: hdl/uart_dce_power_save_wake.sv
// Serial port of a DCE with idle modes and periodic, RTS or DTR wake
`include "uart_dce_defines.svh"
`default_nettype none

// Overview of operation
// - Setting 1: idle when possible, receiver polled periodically
// - Setting 2: RTS going ON wakes port after 20 ms
// - Setting 3: DTR going ON wakes after 20 ms
// - After line wake, drop every character until active
// - Flow control on after reset, command switches it off
// - Flow control hides idle port; host buffers, data arrives later
// - Periodic wake without flow: port on 20 ms after data
// - First character while idle only wakes, is dropped
module uart_dce_power_save_wake #(
  parameter int unsigned WAKE_CYC = `WAKE_CYCLES,
  parameter int unsigned IDLE_CYC = `IDLE_CYCLES,
  parameter int unsigned POLL_CYC = `POLL_CYCLES,
  parameter int unsigned BAUD_DIV = `BAUD_DIVISOR,
  parameter bit HAS_DTR_WAKE = 1'b1,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic rxd,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic power_saving_select_command,
  input wire logic [1:0] psv_setting,
  input wire logic flow_control_on_setting,
  input wire logic flow_control_off_setting,
  input wire logic rx_ready,
  output logic cts_n,
  output logic rx_valid,
  output logic [`UART_DATA_BITS-1:0] rx_data,
  output logic port_active,
  output logic low_power,
  output logic rx_overrun
);
  typedef struct packed {
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    uart_dce_pkg::port_state_t state;
    uart_dce_pkg::psv_mode_t mode;
    logic flow_on;
    logic [31:0] tmr;
    logic rx_busy;
    logic [3:0] bit_cnt;
    logic [15:0] baud;
    logic [`UART_DATA_BITS-1:0] shift;
    logic push_valid;
    logic [`UART_DATA_BITS-1:0] push_data;
    logic overrun;
    logic cts_n;
    logic rx_enabled;
    logic low_power;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  logic rx_level;
  logic rts_edge;
  logic dtr_edge;
  logic idle_allowed;

  stream_if #(.W(`UART_DATA_BITS)) push_if ();
  stream_if #(.W(`UART_DATA_BITS)) pop_if ();

  function automatic logic line_on(input logic level);
    return !level;
  endfunction

  byte_fifo #(
    .W(`UART_DATA_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr(push_if.snk),
    .rd(pop_if.src)
  );

  assign push_if.valid = s.push_valid;
  assign push_if.data = s.push_data;
  assign pop_if.ready = rx_ready;

  assign rx_level = s.pin_sync[0];
  assign rts_edge = line_on(s.pin_sync[1]) && !line_on(s.pin_prev[1]);
  assign dtr_edge = line_on(s.pin_sync[2]) && !line_on(s.pin_prev[2]);
  assign idle_allowed = (s.mode == uart_dce_pkg::PSV_PERIODIC) || (s.mode == uart_dce_pkg::PSV_RTS) ||
    ((s.mode == uart_dce_pkg::PSV_DTR) && HAS_DTR_WAKE);

  always_comb
  begin
    next_s = s;
    next_s.pin_meta = {dtr_n, rts_n, rxd};
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    if (power_saving_select_command)
    begin
      next_s.mode = uart_dce_pkg::psv_mode_t'(psv_setting);
    end
    if (flow_control_off_setting)
    begin
      next_s.flow_on = 1'b0;
    end
    else if (flow_control_on_setting)
    begin
      next_s.flow_on = 1'b1;
    end
    if (s.push_valid && push_if.ready)
    begin
      next_s.push_valid = 1'b0;
    end
    case (s.state)
      uart_dce_pkg::ST_ACTIVE:
      begin
        if (!s.rx_busy)
        begin
          if (!rx_level)
          begin
            next_s.rx_busy = 1'b1;
            next_s.bit_cnt = 4'h0;
            next_s.baud = 16'(BAUD_DIV / 2);
          end
        end
        else if (s.baud != 16'h0)
        begin
          next_s.baud = s.baud - 16'h1;
        end
        else
        begin
          next_s.baud = 16'(BAUD_DIV - 1);
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == 4'h0)
          begin
            next_s.rx_busy = !rx_level;
          end
          else if (s.bit_cnt != 4'(`UART_STOP_INDEX))
          begin
            next_s.shift = {rx_level, s.shift[`UART_DATA_BITS-1:1]};
          end
          else
          begin
            next_s.rx_busy = 1'b0;
            if (rx_level)
            begin
              if (s.push_valid && !push_if.ready)
              begin
                next_s.overrun = 1'b1;
              end
              else
              begin
                next_s.push_valid = 1'b1;
                next_s.push_data = s.shift;
              end
            end
          end
        end
        if (s.rx_busy || s.push_valid || !idle_allowed || !rx_level)
        begin
          next_s.tmr = 32'(IDLE_CYC - 1);
        end
        else if (s.tmr == 32'h0)
        begin
          next_s.state = uart_dce_pkg::ST_IDLE;
          next_s.tmr = 32'(POLL_CYC - 1);
        end
        else
        begin
          next_s.tmr = s.tmr - 32'h1;
        end
      end
      uart_dce_pkg::ST_IDLE:
      begin
        next_s.rx_busy = 1'b0;
        if (s.mode == uart_dce_pkg::PSV_PERIODIC)
        begin
          if (s.flow_on)
          begin
            if (s.tmr == 32'h0)
            begin
              next_s.state = uart_dce_pkg::ST_ACTIVE;
              next_s.tmr = 32'(IDLE_CYC - 1);
            end
            else
            begin
              next_s.tmr = s.tmr - 32'h1;
            end
          end
          else if (!rx_level)
          begin
            next_s.state = uart_dce_pkg::ST_WAKING;
            next_s.tmr = 32'(WAKE_CYC - 1);
          end
        end
        else if (s.mode == uart_dce_pkg::PSV_RTS)
        begin
          if (rts_edge)
          begin
            next_s.state = uart_dce_pkg::ST_WAKING;
            next_s.tmr = 32'(WAKE_CYC - 1);
          end
        end
        else if ((s.mode == uart_dce_pkg::PSV_DTR) && HAS_DTR_WAKE)
        begin
          if (dtr_edge)
          begin
            next_s.state = uart_dce_pkg::ST_WAKING;
            next_s.tmr = 32'(WAKE_CYC - 1);
          end
        end
        else
        begin
          next_s.state = uart_dce_pkg::ST_ACTIVE;
          next_s.tmr = 32'(IDLE_CYC - 1);
        end
      end
      uart_dce_pkg::ST_WAKING:
      begin
        next_s.rx_busy = 1'b0;
        if (s.tmr == 32'h0)
        begin
          next_s.state = uart_dce_pkg::ST_ACTIVE;
          next_s.tmr = 32'(IDLE_CYC - 1);
        end
        else
        begin
          next_s.tmr = s.tmr - 32'h1;
        end
      end
      default:
      begin
        next_s.state = uart_dce_pkg::ST_ACTIVE;
        next_s.rx_busy = 1'b0;
      end
    endcase
    next_s.cts_n = !((next_s.state == uart_dce_pkg::ST_ACTIVE) && push_if.ready);
    next_s.rx_enabled = (next_s.state == uart_dce_pkg::ST_ACTIVE);
    next_s.low_power = (next_s.state == uart_dce_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.pin_meta <= `PIN_IDLE_LEVELS;
      s.pin_sync <= `PIN_IDLE_LEVELS;
      s.pin_prev <= `PIN_IDLE_LEVELS;
      s.state <= uart_dce_pkg::ST_ACTIVE;
      s.mode <= uart_dce_pkg::psv_mode_t'(`PSV_RESET);
      s.flow_on <= `FLOW_ON_RESET;
      s.tmr <= 32'(IDLE_CYC - 1);
      s.cts_n <= 1'b1;
      s.rx_enabled <= 1'b1;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign cts_n = s.cts_n;
  assign rx_valid = pop_if.valid;
  assign rx_data = pop_if.data;
  assign port_active = s.rx_enabled;
  assign low_power = s.low_power;
  assign rx_overrun = s.overrun;

  chk_poll_wake: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s.state == uart_dce_pkg::ST_IDLE && s.mode == uart_dce_pkg::PSV_PERIODIC && s.flow_on &&
    s.tmr == 32'h0 |=> s.state == uart_dce_pkg::ST_ACTIVE && !s.low_power)
    else $error("periodic poll did not reopen the port");

  chk_rts_wake: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s.state == uart_dce_pkg::ST_IDLE && s.mode == uart_dce_pkg::PSV_RTS && rts_edge
    |=> s.state == uart_dce_pkg::ST_WAKING && s.tmr == 32'(WAKE_CYC - 1))
    else $error("RTS ON did not start the wake delay");

  chk_dtr_wake: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && HAS_DTR_WAKE && s.state == uart_dce_pkg::ST_IDLE && s.mode == uart_dce_pkg::PSV_DTR && dtr_edge
    |=> s.state == uart_dce_pkg::ST_WAKING && s.tmr == 32'(WAKE_CYC - 1))
    else $error("DTR ON did not start the wake delay");

  chk_wake_done: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s.state == uart_dce_pkg::ST_WAKING && s.tmr == 32'h0
    |=> s.state == uart_dce_pkg::ST_ACTIVE && s.rx_enabled)
    else $error("port not enabled at end of wake delay");

  chk_active_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s.state == uart_dce_pkg::ST_ACTIVE && s.rx_busy |=> s.state == uart_dce_pkg::ST_ACTIVE)
    else $error("port left active state in mid character");

  chk_idle_cts: assert property (@(posedge clk) disable iff (!rst_n)
    s.state != uart_dce_pkg::ST_ACTIVE |-> s.cts_n && !s.rx_enabled)
    else $error("CTS ON while port is not active");

  chk_wake_char_drop: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s.state != uart_dce_pkg::ST_ACTIVE |=> !$rose(s.push_valid))
    else $error("character taken while port was not active");

  chk_flow_off: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && flow_control_off_setting |=> !s.flow_on)
    else $error("flow control still on after off command");

  chk_flow_default: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> s.flow_on)
    else $error("flow control not on after reset");

  chk_rts_level: assert property (@(posedge clk) disable iff (!rst_n)
    rts_edge && $past(clk_en) |-> !s.pin_sync[1] && $past(s.pin_sync[1], 1))
    else $error("RTS ON taken from a high level");

endmodule // uart_dce_power_save_wake

`default_nettype wire

// file: tb/host_dte_model.sv
// Host-side serial model: 8N1 characters out, modem lines driven
`default_nettype none

module host_dte_model #(
  parameter int BAUD_DIV = 8
) (
  input wire logic clk,
  input wire logic cts_n,
  output logic rxd,
  output logic rts_n,
  output logic dtr_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rxd = 1'b1;
    rts_n = 1'b0;
    dtr_n = 1'b0;
  end

  // Drive RTS or DTR, low means ON
  task automatic set_line(input bit dtr, input bit on);
    @(negedge clk);
    if (dtr)
      dtr_n = ~on;
    else
      rts_n = ~on;
  endtask

  // One character LSB first, then two idle bit times
  task automatic send_byte(input logic [7:0] b, input bit use_flow);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(negedge clk);
    while (use_flow && cts_n !== 1'b0)
      @(negedge clk);
    for (int i = 0; i < 10; i++)
    begin
      rxd = frame[i];
      repeat (BAUD_DIV) @(negedge clk);
    end
    repeat (2 * BAUD_DIV) @(negedge clk);
  endtask
endmodule // host_dte_model

`default_nettype wire

// file: tb/test_uart_dce_power_save_wake.sv
// Self-checking bench for the power-saving serial port
`default_nettype none

module test_uart_dce_power_save_wake;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WAKE_CYC = 50;
  localparam int IDLE_CYC = 100;
  localparam int POLL_CYC = 30;
  localparam int BAUD_DIV = 8;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic power_saving_select_command = 1'b0;
  logic [1:0] psv_setting = 2'h0;
  logic flow_control_on_setting = 1'b0;
  logic flow_control_off_setting = 1'b0;
  logic rx_ready = 1'b0;
  logic stall = 1'b1;
  logic rxd, rts_n, dtr_n, cts_n, rx_valid, port_active, low_power, rx_overrun;
  logic [7:0] rx_data;
  logic [7:0] byte_q[$];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  always #5 clk = ~clk;

  uart_dce_power_save_wake #(.WAKE_CYC(WAKE_CYC), .IDLE_CYC(IDLE_CYC), .POLL_CYC(POLL_CYC),
    .BAUD_DIV(BAUD_DIV)) i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .rxd(rxd),
    .rts_n(rts_n), .dtr_n(dtr_n), .power_saving_select_command(power_saving_select_command),
    .psv_setting(psv_setting), .flow_control_on_setting(flow_control_on_setting),
    .flow_control_off_setting(flow_control_off_setting), .rx_ready(rx_ready), .cts_n(cts_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .port_active(port_active), .low_power(low_power),
    .rx_overrun(rx_overrun));

  host_dte_model #(.BAUD_DIV(BAUD_DIV)) i_host (.clk(clk), .cts_n(cts_n), .rxd(rxd),
    .rts_n(rts_n), .dtr_n(dtr_n));

  task automatic report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_flag(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmd_psv(input logic [1:0] s);
    @(negedge clk);
    power_saving_select_command = 1'b1;
    psv_setting = s;
    @(negedge clk);
    power_saving_select_command = 1'b0;
  endtask

  task automatic cmd_flow(input bit on);
    @(negedge clk);
    if (on)
      flow_control_on_setting = 1'b1;
    else
      flow_control_off_setting = 1'b1;
    @(negedge clk);
    flow_control_on_setting = 1'b0;
    flow_control_off_setting = 1'b0;
  endtask

  // Noted bytes are expected in order at the consumer side
  task automatic host_send(input logic [7:0] b, input bit flow, input bit keep);
    if (keep)
      byte_q.push_back(b);
    i_host.send_byte(b, flow);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (low_power !== 1'b1 && k < IDLE_CYC + 40)
    begin
      @(negedge clk);
      k++;
    end
    cmp_flag("low_power", 1'b1, low_power);
    cmp_flag("cts_n_idle", 1'b1, cts_n);
    cmp_flag("port_active_idle", 1'b0, port_active);
  endtask

  task automatic wait_active(output int k);
    k = 0;
    @(negedge clk);
    while (port_active !== 1'b1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic drain;
    for (int k = 0; k < 3000 && byte_q.size() != 0; k++)
      @(negedge clk);
    cmp_flag("queue_empty", 1'b1, byte_q.size() == 0);
  endtask

  // Consumer side: random stalls, compare each accepted byte
  always @(negedge clk)
    rx_ready <= stall ? 1'b0 : 1'($urandom);

  always @(posedge clk)
    if (rst_n === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      if (byte_q.size() == 0)
        cmp_flag("byte_expected", 1'b1, 1'b0);
      else
        cmp_byte("rx_data", byte_q.pop_front(), rx_data);
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h53764A0E));
    repeat (2) @(negedge clk);
    cmp_flag("cts_n_reset", 1'b1, cts_n);
    cmp_flag("low_power_reset", 1'b0, low_power);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    stall = 1'b0;
    repeat (4) @(negedge clk);
    cmp_flag("cts_n_on", 1'b0, cts_n);
    // Setting 0: traffic, never idles
    repeat (4) host_send(8'($urandom), 1'b0, 1'b1);
    repeat (IDLE_CYC + 20) @(negedge clk);
    cmp_flag("no_idle", 1'b0, low_power);
    // Setting 1 with default flow control: periodic poll, host holds back
    cmd_psv(uart_dce_pkg::PSV_PERIODIC);
    wait_idle();
    wait_active(n);
    cmp_flag("poll_delay", 1'b1, n >= POLL_CYC - 2 && n <= POLL_CYC + 6);
    wait_idle();
    host_send(8'($urandom), 1'b1, 1'b1);
    drain();
    // Setting 1 without flow control: wake character dropped
    cmd_flow(1'b0);
    wait_idle();
    fork
      host_send(8'hFF, 1'b0, 1'b0);
      wait_active(n);
    join
    cmp_flag("data_wake", 1'b1, n >= WAKE_CYC && n <= WAKE_CYC + 8);
    host_send(8'($urandom), 1'b0, 1'b1);
    drain();
    // Setting 2 then 3: line-triggered wake, flow control still off
    for (int m = 0; m < 2; m++)
    begin
      cmd_psv(m == 0 ? uart_dce_pkg::PSV_RTS : uart_dce_pkg::PSV_DTR);
      wait_idle();
      i_host.set_line(m == 1, 1'b0);
      repeat (4) @(negedge clk);
      cmp_flag("still_idle", 1'b1, low_power);
      i_host.set_line(m == 1, 1'b1);
      wait_active(n);
      cmp_flag("line_wake", 1'b1, n >= WAKE_CYC && n <= WAKE_CYC + 8);
      repeat (2) host_send(8'($urandom), 1'b0, 1'b1);
      drain();
    end
    // Full buffer with flow control: CTS holds the host back
    cmd_flow(1'b1);
    cmd_psv(uart_dce_pkg::PSV_OFF);
    stall = 1'b1;
    repeat (17) host_send(8'($urandom), 1'b1, 1'b1);
    repeat (20) @(negedge clk);
    cmp_flag("cts_n_full", 1'b1, cts_n);
    fork
      repeat (2) host_send(8'($urandom), 1'b1, 1'b1);
      begin
        repeat (100) @(negedge clk);
        cmp_flag("rx_overrun", 1'b0, rx_overrun);
        stall = 1'b0;
      end
    join
    drain();
    report_and_stop();
  end
endmodule // test_uart_dce_power_save_wake

`default_nettype wire
